// ---- rtl/lpm_controller.v ----
// Low-power mode sequencer: clock gating, memory and regulator control.
`timescale 1ns/10ps
`default_nettype none
`include "lpm_map.vh"
module lpm_controller #(
  parameter CNT_W = `LPM_CNT_W,
  parameter SLOW_WAKE_CYC = `LPM_SLOW_WAKE_CYC,
  parameter FAST_WAKE_CYC = `LPM_FAST_WAKE_CYC
) (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // CPU requests, one-cycle pulses.
  input wire wait_for_event_instruction,
  input wire wait_for_interrupt_instruction,
  input wire haltReq,
  input wire activeHaltReq,
  input wire lpRunEnter,
  input wire lpRunExit,
  // Configuration levels.
  input wire fastWakeup,
  input wire refOffInHalt,
  input wire useLowSpeedExt,
  // Wake sources.
  input wire anyIrq,
  input wire extIrq,
  input wire rtcIrq,
  input wire periphEvent,
  input wire haltWakeReq,
  // Controls.
  output reg cpuClkEn,
  output reg periphClkEn,
  output reg rtcClkEn,
  output reg flashEn,
  output reg regUlp,
  output reg refEn,
  output reg low_speed_internal_osc,
  output reg low_speed_external_osc,
  output reg irqToCpu,
  output reg [`LPM_MODE_W-1:0] mode
);
  // Wake counts are cut to the counter width on purpose.
  // A count that needs more bits also needs a wider CNT_W.
  localparam integer SLOW_INT = SLOW_WAKE_CYC;
  localparam integer FAST_INT = FAST_WAKE_CYC;
  localparam [CNT_W-1:0] SLOW_CNT = SLOW_INT[CNT_W-1:0];
  localparam [CNT_W-1:0] FAST_CNT = FAST_INT[CNT_W-1:0];
  reg [`LPM_MODE_W-1:0] next_mode;
  reg pendIrq;
  reg next_pendIrq;
  reg timerStart;
  reg [CNT_W-1:0] timerCount;
  wire timerDone;

  // Both low power run modes share their supply and memory settings.
  function lowPowerRun;
    input [`LPM_MODE_W-1:0] m;
    begin
      case (m)
        `LPM_LPRUN, `LPM_LPWAIT: begin
          lowPowerRun = 1'b1;
        end
        default: begin
          lowPowerRun = 1'b0;
        end
      endcase
    end
  endfunction

  // Both halt modes stop the peripherals and may drop the reference.
  function haltStop;
    input [`LPM_MODE_W-1:0] m;
    begin
      case (m)
        `LPM_HALT, `LPM_AHALT: begin
          haltStop = 1'b1;
        end
        default: begin
          haltStop = 1'b0;
        end
      endcase
    end
  endfunction

  function cpuRuns;
    input [`LPM_MODE_W-1:0] m;
    begin
      case (m)
        `LPM_RUN, `LPM_LPRUN: begin
          cpuRuns = 1'b1;
        end
        default: begin
          cpuRuns = 1'b0;
        end
      endcase
    end
  endfunction

  // Peripheral clocks come back while waking, ahead of the CPU clock.
  function periphRuns;
    input [`LPM_MODE_W-1:0] m;
    begin
      case (m)
        `LPM_RUN, `LPM_WAIT, `LPM_LPRUN, `LPM_LPWAIT, `LPM_WAKE: begin
          periphRuns = 1'b1;
        end
        default: begin
          periphRuns = 1'b0;
        end
      endcase
    end
  endfunction

  function rtcRuns;
    input [`LPM_MODE_W-1:0] m;
    begin
      case (m)
        `LPM_HALT: begin
          rtcRuns = 1'b0;
        end
        default: begin
          rtcRuns = 1'b1;
        end
      endcase
    end
  endfunction

  // The long count is only needed when the reference was really off.
  function [CNT_W-1:0] wakeCount;
    input fast;
    input refOff;
    begin
      if (fast || !refOff) begin
        wakeCount = FAST_CNT;
      end else begin
        wakeCount = SLOW_CNT;
      end
    end
  endfunction

  lpm_wake_timer #(.CNT_W(CNT_W)) wakeTimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(timerStart),
    .count(timerCount),
    .done(timerDone)
  );

  always @* begin
    next_mode = mode;
    next_pendIrq = pendIrq;
    timerStart = 1'b0;
    timerCount = FAST_CNT;
    case (mode)
      `LPM_RUN: begin
        if (wait_for_event_instruction || wait_for_interrupt_instruction) begin
          next_mode = `LPM_WAIT;
        end else if (lpRunEnter) begin
          next_mode = `LPM_LPRUN;
        end else if (activeHaltReq) begin
          next_mode = `LPM_AHALT;
        end else if (haltReq) begin
          next_mode = `LPM_HALT;
        end
      end
      `LPM_WAIT: begin
        if (anyIrq || periphEvent) begin
          next_mode = `LPM_RUN;
          next_pendIrq = anyIrq;
        end
      end
      `LPM_LPRUN: begin
        // Interrupts are deliberately not looked at here.
        if (lpRunExit) begin
          next_mode = `LPM_RUN;
        end else if (wait_for_event_instruction) begin
          next_mode = `LPM_LPWAIT;
        end
      end
      `LPM_LPWAIT: begin
        if (periphEvent) begin
          next_mode = `LPM_LPRUN;
        end
      end
      `LPM_AHALT: begin
        if (rtcIrq || extIrq) begin
          next_mode = `LPM_WAKE;
          next_pendIrq = 1'b1;
          timerStart = 1'b1;
          timerCount = wakeCount(fastWakeup, refOffInHalt);
        end
      end
      `LPM_HALT: begin
        if (extIrq || haltWakeReq) begin
          next_mode = `LPM_WAKE;
          next_pendIrq = extIrq;
          timerStart = 1'b1;
          // Fast wakeup does not wait for the reference to settle.
          timerCount = wakeCount(fastWakeup, refOffInHalt);
        end
      end
      `LPM_WAKE: begin
        if (timerDone) begin
          next_mode = `LPM_RUN;
        end
      end
      default: begin
        next_mode = `LPM_RUN;
      end
    endcase
    if (pendIrq && (mode == `LPM_RUN) && cpuClkEn) begin
      next_pendIrq = 1'b0;
    end
  end

  // Outputs other than irqToCpu are registered from the next mode so they track it exactly; irqToCpu is registered from the current mode and pendIrq.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= `LPM_RUN;
      pendIrq <= 1'b0;
      cpuClkEn <= 1'b1;
      periphClkEn <= 1'b1;
      rtcClkEn <= 1'b1;
      flashEn <= 1'b1;
      regUlp <= 1'b0;
      refEn <= 1'b1;
      low_speed_internal_osc <= 1'b0;
      low_speed_external_osc <= 1'b0;
      irqToCpu <= 1'b0;
    end else begin
      mode <= next_mode;
      pendIrq <= next_pendIrq;
      cpuClkEn <= cpuRuns(next_mode);
      periphClkEn <= periphRuns(next_mode);
      rtcClkEn <= rtcRuns(next_mode);
      flashEn <= !(lowPowerRun(next_mode) || haltStop(next_mode));
      regUlp <= lowPowerRun(next_mode);
      refEn <= !(haltStop(next_mode) && refOffInHalt);
      low_speed_internal_osc <= lowPowerRun(next_mode) &&
        !useLowSpeedExt;
      low_speed_external_osc <= lowPowerRun(next_mode) &&
        useLowSpeedExt;
      irqToCpu <= pendIrq && (mode == `LPM_RUN) && cpuClkEn;
    end
  end
endmodule // lpm_controller
`default_nettype wire

// ---- rtl/lpm_map.vh ----
// Constants for the low-power mode controller.
`ifndef LPM_MAP_VH
`define LPM_MAP_VH
`define LPM_MODE_W 3
`define LPM_RUN 3'h0
`define LPM_WAIT 3'h1
`define LPM_LPRUN 3'h2
`define LPM_LPWAIT 3'h3
`define LPM_AHALT 3'h4
`define LPM_HALT 3'h5
`define LPM_WAKE 3'h6
`define LPM_FAST_WAKE_NS 5000
`define LPM_CLK_NS 4
`define LPM_FAST_WAKE_CYC ((`LPM_FAST_WAKE_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)
`define LPM_SLOW_WAKE_CYC 2500
`define LPM_CNT_W 16
`define LPM_CNT_ONE 16'h0001
`define LPM_CNT_ZERO 16'h0000
`endif

// ---- rtl/lpm_wake_timer.v ----
// Wakeup delay counter used before clocks are released to the CPU.
`timescale 1ns/10ps
`default_nettype none
`include "lpm_map.vh"
module lpm_wake_timer #(
  parameter CNT_W = `LPM_CNT_W
) (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // Control.
  input wire start,
  input wire [CNT_W-1:0] count,
  output reg done
);
  reg [CNT_W-1:0] remain;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= {CNT_W{1'b0}};
      done <= 1'b0;
    end else if (start) begin
      remain <= count;
      done <= 1'b0;
    end else if (remain != {CNT_W{1'b0}}) begin
      remain <= remain - {{(CNT_W-1){1'b0}}, 1'b1};
      done <= (remain == {{(CNT_W-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b0;
    end
  end
endmodule // lpm_wake_timer
`default_nettype wire

// ---- verif/lpm_chk.sv ----
// Port checks for the low-power mode controller.
`timescale 1ns/10ps
`default_nettype none
`include "lpm_map.vh"
module lpm_chk (
  input wire logic mclk, rst_n, anyIrq, periphEvent, fastWakeup,
  input wire logic wait_for_event_instruction, extIrq, irqToCpu,
  input wire logic cpuClkEn, periphClkEn, rtcClkEn, flashEn, regUlp,
  input wire logic [2:0] mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Fast count of two in simulation gives three waking cycles.
  sequence s_wake;
    (mode == `LPM_WAKE && !cpuClkEn)[*3] ##1 mode == `LPM_RUN && cpuClkEn;
  endsequence
  a_wait_clk: assert property (mode == `LPM_WAIT |->
    !cpuClkEn && periphClkEn) else $error("wait clocks");
  a_wait_exit: assert property (mode == `LPM_WAIT && anyIrq |=>
    mode == `LPM_RUN) else $error("wait exit");
  a_lprun_cfg: assert property (mode == `LPM_LPRUN |->
    cpuClkEn && !flashEn && regUlp) else $error("lprun setup");
  a_lpwait_hold: assert property (mode == `LPM_LPWAIT && !periphEvent |=>
    mode == `LPM_LPWAIT) else $error("lpwait left");
  a_lpwait_in: assert property (mode == `LPM_LPRUN &&
    wait_for_event_instruction |=> mode == `LPM_LPWAIT && !cpuClkEn &&
    !flashEn) else $error("lpwait entry");
  a_lpwait_out: assert property (mode == `LPM_LPWAIT && periphEvent |=>
    mode == `LPM_LPRUN && cpuClkEn) else $error("lpwait exit");
  a_halt_clk: assert property (mode inside {`LPM_HALT, `LPM_AHALT} |->
    !cpuClkEn && !periphClkEn && rtcClkEn == (mode == `LPM_AHALT))
    else $error("halt clocks");
  a_wake_clk: assert property (mode == `LPM_WAKE |->
    !cpuClkEn && periphClkEn) else $error("wake clocks");
  a_irq_once: assert property (irqToCpu |=> !irqToCpu)
    else $error("irq pulse");
  a_fast_wake: assert property (mode == `LPM_HALT && extIrq &&
    fastWakeup |=> s_wake ##1 irqToCpu) else $error("fast wake");
endmodule // lpm_chk
`default_nettype wire

// ---- verif/lpm_src_model.sv ----
// Request and wake source model driving one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module lpm_src_model (
  input wire logic mclk,
  output logic [10:0] req
);
  initial req = 11'h000;
  // Pulses rise just after an edge so exactly one edge samples them.
  task pulse(input int b);
    @(posedge mclk) #1 req = 11'h001 << b;
    @(posedge mclk) #1 req = 11'h000;
  endtask
endmodule // lpm_src_model
`default_nettype wire

// ---- verif/lpm_tb.sv ----
// Self-checking bench for the low-power mode controller.
`timescale 1ns/10ps
`default_nettype none
`include "lpm_map.vh"
module testbench;
  logic mclk, rst_n, fastWakeup, refOffInHalt, useLowSpeedExt;
  logic cpuClkEn, periphClkEn, rtcClkEn, flashEn, regUlp, refEn;
  logic oscInt, oscExt, irqToCpu;
  logic [2:0] mode;
  logic [10:0] req;
  int err_total = 0;
  int check_count = 0;
  lpm_src_model src (.mclk(mclk), .req(req));
  lpm_controller #(.SLOW_WAKE_CYC(4), .FAST_WAKE_CYC(2)) DUT (.mclk,
    .rst_n, .wait_for_event_instruction(req[0]),
    .wait_for_interrupt_instruction(req[1]), .haltReq(req[2]),
    .activeHaltReq(req[3]), .lpRunEnter(req[4]), .lpRunExit(req[5]),
    .fastWakeup, .refOffInHalt, .useLowSpeedExt, .anyIrq(req[6]),
    .extIrq(req[7]), .rtcIrq(req[8]), .periphEvent(req[9]),
    .haltWakeReq(req[10]), .cpuClkEn, .periphClkEn, .rtcClkEn, .flashEn,
    .regUlp, .refEn, .low_speed_internal_osc(oscInt),
    .low_speed_external_osc(oscExt), .irqToCpu, .mode);
  task chk(input string n, input [2:0] e, input [2:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task t_wait(input int i, w);
    src.pulse(i);
    chk("mode", `LPM_WAIT, mode);
    src.pulse(w);
    chk("mode", `LPM_RUN, mode);
    @(posedge mclk) #1 chk("irqToCpu", {2'h0, w == 6}, irqToCpu);
    $display("wait test done");
  endtask
  task t_lp(input logic x);
    useLowSpeedExt = x;
    src.pulse(4);
    chk("lp cfg", {2'h1, !x}, {flashEn, regUlp, oscInt});
    chk("lp osc", {2'h0, x}, {2'h0, oscExt});
    src.pulse(6);
    src.pulse(1);
    chk("mode", `LPM_LPRUN, mode);
    src.pulse(0);
    chk("mode", `LPM_LPWAIT, mode);
    src.pulse(9);
    chk("mode", `LPM_LPRUN, mode);
    src.pulse(5);
    chk("mode", `LPM_RUN, mode);
    $display("lp test done");
  endtask
  task t_reset;
    src.pulse(4);
    chk("mode", `LPM_LPRUN, mode);
    rst_n = 1'b0;
    #1 chk("mode", `LPM_RUN, mode);
    @(posedge mclk) #1 rst_n = 1'b1;
    chk("lp cfg", 3'h4, {flashEn, regUlp, oscInt});
    chk("lp osc", 3'h0, {2'h0, oscExt});
    $display("reset test done");
  endtask
  task t_halt(input int r, w, n, input logic f, o);
    fastWakeup = f;
    refOffInHalt = o;
    src.pulse(r);
    chk("clocks", {2'h0, r == 3}, {cpuClkEn, periphClkEn, rtcClkEn});
    chk("refEn", {2'h0, !o}, {2'h0, refEn});
    src.pulse(w);
    repeat (n) @(posedge mclk);
    #1 chk("mode", `LPM_WAKE, mode);
    @(posedge mclk) #1 chk("mode", `LPM_RUN, mode);
    @(posedge mclk) #1 chk("irqToCpu", {2'h0, w != 10}, irqToCpu);
    $display("halt test done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    fastWakeup = 1'b1;
    refOffInHalt = 1'b1;
    useLowSpeedExt = 1'b0;
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk("mode", `LPM_RUN, mode);
    t_wait(1, 6);
    t_wait(0, 9);
    t_lp(1'b0);
    t_lp(1'b1);
    t_reset;
    t_halt(2, 7, 2, 1'b1, 1'b1);
    t_halt(2, 7, 4, 1'b0, 1'b1);
    t_halt(2, 7, 2, 1'b0, 1'b0);
    t_halt(3, 8, 2, 1'b1, 1'b1);
    t_halt(2, 10, 2, 1'b1, 1'b1);
    test_done;
  end
  initial begin
    #4000;
    err_total++;
    test_done;
  end
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
endmodule // testbench
bind lpm_controller lpm_chk chk_i (.mclk, .rst_n, .anyIrq, .periphEvent,
  .fastWakeup, .wait_for_event_instruction, .extIrq, .irqToCpu, .cpuClkEn,
  .periphClkEn, .rtcClkEn, .flashEn, .regUlp, .mode);
`default_nettype wire
